// >>> core/cso_pkg.sv
// Shared constants and types for the sync, verify and error-policy objects.
//
// Operation
// - Device holds writable sync counter wrap value.
// - Wrap value 8-bit, resets zero, writes 02h-F0h.
// - Date entry counts days since 1 January 1984.
// - Time entry counts milliseconds since last midnight.
// - Write date and time before starting store.
// - Stored stamp survives reset for later read-back.
// - Comm error: 00 preop-if-operational, 01 keep, 02 stop.
// - Other errors: same codes, separate policy, reset 01.
package cso_pkg;
   localparam logic [15:0] IDX_STORE = 16'h1010;
   localparam logic [15:0] IDX_SYNC_WRAP = 16'h1019;
   localparam logic [15:0] IDX_VERIFY = 16'h1020;
   localparam logic [15:0] IDX_ERR_BEH = 16'h1029;
   localparam logic [7:0] SUB_ZERO = 8'h00;
   localparam logic [7:0] SUB_FIRST = 8'h01;
   localparam logic [7:0] SUB_SECOND = 8'h02;
   localparam logic [7:0] ARRAY_ENTRIES = 8'h02;
   localparam logic [7:0] WRAP_MIN = 8'h02;
   localparam logic [7:0] WRAP_MAX = 8'hF0;
   localparam logic [7:0] WRAP_RST = 8'h00;
   localparam logic [7:0] COMM_POL_RST = 8'h00;
   localparam logic [7:0] INT_POL_RST = 8'h01;
   localparam logic [31:0] STAMP_RST = 32'h00000000;
   localparam logic [7:0] POL_PREOP = 8'h00;
   localparam logic [7:0] POL_KEEP = 8'h01;
   localparam logic [7:0] POL_STOP = 8'h02;
   localparam logic [7:0] CNT_ONE = 8'h01;
   localparam logic [7:0] CNT_RST = 8'h00;
   typedef enum logic [1:0] {CSO_PREOP, CSO_OPER, CSO_STOPPED} cso_nmt_t;
   typedef enum logic [1:0] {CSO_CMD_START, CSO_CMD_STOP, CSO_CMD_PREOP} cso_nmt_cmd_t;
endpackage : cso_pkg

// >>> core/cso_link_if.sv
// Object access, SYNC and NMT link between the master end and the device end.
interface cso_link_if;
   import cso_pkg::*;
   logic req;
   logic wr;
   logic [15:0] idx;
   logic [7:0] sub;
   logic [31:0] wdata;
   logic ack;
   logic abort;
   logic [31:0] rdata;
   logic sync;
   logic nmt_vld;
   cso_nmt_cmd_t nmt_cmd;
   cso_nmt_t nmt_state;
   modport dev (input req, wr, idx, sub, wdata, sync, nmt_vld, nmt_cmd,
                output ack, abort, rdata, nmt_state);
   modport mst (output req, wr, idx, sub, wdata, sync, nmt_vld, nmt_cmd,
                input ack, abort, rdata, nmt_state);
endinterface : cso_link_if

// >>> core/cso_sync_ctr.sv
// SYNC counter that wraps at a configurable value.
module cso_sync_ctr
   import cso_pkg::*;
#(
   parameter int CNT_W = 8
) (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic sync_i,
   input wire logic [CNT_W-1:0] wrap_i,
   output logic [CNT_W-1:0] cnt_o
);
   if (CNT_W != 8) begin : g_chk
      $error("cso_sync_ctr: CNT_W must be 8");
   end

   logic [CNT_W-1:0] cnt_d;
   logic [CNT_W-1:0] cnt_q;

   // A zero wrap value disables counting and holds the counter at zero.
   always_comb begin
      cnt_d = cnt_q;
      if (wrap_i == WRAP_RST) begin
         cnt_d = CNT_RST;
      end else if (sync_i) begin
         if (cnt_q >= wrap_i || cnt_q == CNT_RST) begin
            cnt_d = CNT_ONE;
         end else begin
            cnt_d = cnt_q + CNT_ONE;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_q <= CNT_RST;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign cnt_o = cnt_q;
endmodule : cso_sync_ctr

// >>> core/cso_dev.sv
// Device end: object dictionary entries, stamp store, SYNC counter and NMT error reaction.
module cso_dev
   import cso_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic nv_clr_i,
   input wire logic comm_err_i,
   input wire logic int_err_i,
   cso_link_if.dev lnk,
   output cso_nmt_t nmt_state_o,
   output logic [7:0] sync_cnt_o,
   output logic [7:0] wrap_o
);
   logic [7:0] wrap_d;
   logic [7:0] wrap_q;
   logic [31:0] day_d;
   logic [31:0] day_q;
   logic [31:0] ms_d;
   logic [31:0] ms_q;
   logic [7:0] comm_pol_d;
   logic [7:0] comm_pol_q;
   logic [7:0] int_pol_d;
   logic [7:0] int_pol_q;
   logic ack_d;
   logic ack_q;
   logic abort_d;
   logic abort_q;
   logic [31:0] rdata_d;
   logic [31:0] rdata_q;
   logic restore_q;
   logic store_d;
   logic store_q;
   logic [31:0] nv_day_d;
   logic [31:0] nv_day_q;
   logic [31:0] nv_ms_d;
   logic [31:0] nv_ms_q;
   cso_nmt_t nmt_d;
   cso_nmt_t nmt_q;
   logic [7:0] cnt;
   logic sync_ok;

   function automatic cso_nmt_t react(input cso_nmt_t st, input logic [7:0] pol);
      cso_nmt_t res;
      res = st;
      if (pol == POL_PREOP) begin
         if (st == CSO_OPER) begin
            res = CSO_PREOP;
         end
      end else if (pol == POL_STOP) begin
         res = CSO_STOPPED;
      end
      return res;
   endfunction : react

   function automatic logic pol_ok(input logic [31:0] v);
      return v <= {24'h000000, POL_STOP};
   endfunction : pol_ok

   // Object access: every request is answered one cycle later by ack or abort.
   always_comb begin
      wrap_d = wrap_q;
      day_d = day_q;
      ms_d = ms_q;
      comm_pol_d = comm_pol_q;
      int_pol_d = int_pol_q;
      ack_d = 1'b0;
      abort_d = 1'b0;
      rdata_d = rdata_q;
      store_d = 1'b0;
      if (restore_q) begin
         day_d = nv_day_q;
         ms_d = nv_ms_q;
      end
      if (lnk.req) begin
         abort_d = 1'b1;
         if (lnk.idx == IDX_SYNC_WRAP && lnk.sub == SUB_ZERO) begin
            if (!lnk.wr) begin
               rdata_d = {24'h000000, wrap_q};
               abort_d = 1'b0;
            end else if (lnk.wdata >= {24'h000000, WRAP_MIN} && lnk.wdata <= {24'h000000, WRAP_MAX}) begin
               wrap_d = lnk.wdata[7:0];
               abort_d = 1'b0;
            end
         end else if (lnk.idx == IDX_VERIFY) begin
            if (lnk.sub == SUB_ZERO && !lnk.wr) begin
               rdata_d = {24'h000000, ARRAY_ENTRIES};
               abort_d = 1'b0;
            end else if (lnk.sub == SUB_FIRST) begin
               abort_d = 1'b0;
               if (lnk.wr) begin
                  day_d = lnk.wdata;
               end else begin
                  rdata_d = day_q;
               end
            end else if (lnk.sub == SUB_SECOND) begin
               abort_d = 1'b0;
               if (lnk.wr) begin
                  ms_d = lnk.wdata;
               end else begin
                  rdata_d = ms_q;
               end
            end
         end else if (lnk.idx == IDX_ERR_BEH) begin
            if (lnk.sub == SUB_ZERO && !lnk.wr) begin
               rdata_d = {24'h000000, ARRAY_ENTRIES};
               abort_d = 1'b0;
            end else if (lnk.sub == SUB_FIRST) begin
               if (!lnk.wr) begin
                  rdata_d = {24'h000000, comm_pol_q};
                  abort_d = 1'b0;
               end else if (pol_ok(lnk.wdata)) begin
                  comm_pol_d = lnk.wdata[7:0];
                  abort_d = 1'b0;
               end
            end else if (lnk.sub == SUB_SECOND) begin
               if (!lnk.wr) begin
                  rdata_d = {24'h000000, int_pol_q};
                  abort_d = 1'b0;
               end else if (pol_ok(lnk.wdata)) begin
                  int_pol_d = lnk.wdata[7:0];
                  abort_d = 1'b0;
               end
            end
         end else if (lnk.idx == IDX_STORE && lnk.sub == SUB_FIRST && lnk.wr) begin
            store_d = 1'b1;
            abort_d = 1'b0;
         end
         ack_d = !abort_d;
      end
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wrap_q <= WRAP_RST;
         day_q <= STAMP_RST;
         ms_q <= STAMP_RST;
         comm_pol_q <= COMM_POL_RST;
         int_pol_q <= INT_POL_RST;
         ack_q <= 1'b0;
         abort_q <= 1'b0;
         rdata_q <= STAMP_RST;
         store_q <= 1'b0;
         restore_q <= 1'b1;
      end else begin
         wrap_q <= wrap_d;
         day_q <= day_d;
         ms_q <= ms_d;
         comm_pol_q <= comm_pol_d;
         int_pol_q <= int_pol_d;
         ack_q <= ack_d;
         abort_q <= abort_d;
         rdata_q <= rdata_d;
         store_q <= store_d;
         restore_q <= 1'b0;
      end
   end

   // Non-volatile copy of the stamp: no reset, so it outlives nrst_i.
   always_comb begin
      nv_day_d = nv_day_q;
      nv_ms_d = nv_ms_q;
      if (nv_clr_i) begin
         nv_day_d = STAMP_RST;
         nv_ms_d = STAMP_RST;
      end else if (store_q) begin
         nv_day_d = day_q;
         nv_ms_d = ms_q;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      nv_day_q <= nv_day_d;
      nv_ms_q <= nv_ms_d;
   end

   // NMT state: commands first, then error reactions, which take precedence.
   always_comb begin
      nmt_d = nmt_q;
      if (lnk.nmt_vld) begin
         case (lnk.nmt_cmd)
            CSO_CMD_START: nmt_d = CSO_OPER;
            CSO_CMD_STOP: nmt_d = CSO_STOPPED;
            default: nmt_d = CSO_PREOP;
         endcase
      end
      if (comm_err_i) begin
         nmt_d = react(nmt_d, comm_pol_q);
      end
      if (int_err_i) begin
         nmt_d = react(nmt_d, int_pol_q);
      end
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         nmt_q <= CSO_PREOP;
      end else begin
         nmt_q <= nmt_d;
      end
   end

   // SYNC is not served in Stopped.
   assign sync_ok = lnk.sync && nmt_q != CSO_STOPPED;

   cso_sync_ctr #(
      .CNT_W(8)
   ) cso_sync_ctr_i (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .sync_i(sync_ok),
      .wrap_i(wrap_q),
      .cnt_o(cnt)
   );

   assign lnk.ack = ack_q;
   assign lnk.abort = abort_q;
   assign lnk.rdata = rdata_q;
   assign lnk.nmt_state = nmt_q;
   assign nmt_state_o = nmt_q;
   assign sync_cnt_o = cnt;
   assign wrap_o = wrap_q;
endmodule : cso_dev

// >>> core/cso_mst.sv
// Master end: issues object accesses, SYNC and NMT commands over the link.
module cso_mst
   import cso_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic cmd_vld_i,
   input wire logic cmd_wr_i,
   input wire logic [15:0] cmd_idx_i,
   input wire logic [7:0] cmd_sub_i,
   input wire logic [31:0] cmd_wdata_i,
   input wire logic sync_req_i,
   input wire logic nmt_req_i,
   input wire cso_nmt_cmd_t nmt_cmd_i,
   cso_link_if.mst lnk,
   output logic cmd_rdy_o,
   output logic rsp_vld_o,
   output logic rsp_abort_o,
   output logic [31:0] rsp_data_o
);
   typedef enum logic {M_IDLE, M_WAIT} cso_mst_st_t;
   cso_mst_st_t st_d;
   cso_mst_st_t st_q;
   logic req_d;
   logic req_q;
   logic wr_d;
   logic wr_q;
   logic [15:0] idx_d;
   logic [15:0] idx_q;
   logic [7:0] sub_d;
   logic [7:0] sub_q;
   logic [31:0] wdata_d;
   logic [31:0] wdata_q;
   logic vld_d;
   logic vld_q;
   logic abt_d;
   logic abt_q;
   logic [31:0] data_d;
   logic [31:0] data_q;
   logic date_ok_d;
   logic date_ok_q;
   logic time_ok_d;
   logic time_ok_q;
   logic sync_q;
   logic nmt_vld_q;
   cso_nmt_cmd_t nmt_cmd_q;
   logic bad_wrap;
   logic bad_store;
   logic rdy_d;
   logic rdy_q;

   assign bad_wrap = cmd_wr_i && cmd_idx_i == IDX_SYNC_WRAP &&
                     (cmd_wdata_i < {24'h000000, WRAP_MIN} || cmd_wdata_i > {24'h000000, WRAP_MAX});
   assign bad_store = cmd_wr_i && cmd_idx_i == IDX_STORE && !(date_ok_q && time_ok_q);

   always_comb begin
      st_d = st_q;
      req_d = 1'b0;
      wr_d = wr_q;
      idx_d = idx_q;
      sub_d = sub_q;
      wdata_d = wdata_q;
      vld_d = 1'b0;
      abt_d = 1'b0;
      data_d = data_q;
      date_ok_d = date_ok_q;
      time_ok_d = time_ok_q;
      case (st_q)
         M_IDLE: begin
            if (cmd_vld_i && rdy_q) begin
               if (bad_wrap || bad_store) begin
                  vld_d = 1'b1;
                  abt_d = 1'b1;
               end else begin
                  req_d = 1'b1;
                  wr_d = cmd_wr_i;
                  idx_d = cmd_idx_i;
                  sub_d = cmd_sub_i;
                  wdata_d = cmd_wdata_i;
                  st_d = M_WAIT;
               end
            end
         end
         default: begin
            if (lnk.ack || lnk.abort) begin
               vld_d = 1'b1;
               abt_d = lnk.abort;
               data_d = lnk.rdata;
               st_d = M_IDLE;
               if (lnk.ack && wr_q && idx_q == IDX_VERIFY) begin
                  if (sub_q == SUB_FIRST) begin
                     date_ok_d = 1'b1;
                  end
                  if (sub_q == SUB_SECOND) begin
                     time_ok_d = 1'b1;
                  end
               end
               if (lnk.ack && wr_q && idx_q == IDX_STORE) begin
                  date_ok_d = 1'b0;
                  time_ok_d = 1'b0;
               end
            end
         end
      endcase
      // Ready is registered: it falls from the taking edge until the cycle after the answer.
      rdy_d = st_d == M_IDLE && !vld_d && !req_d;
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_q <= M_IDLE;
         req_q <= 1'b0;
         wr_q <= 1'b0;
         idx_q <= IDX_STORE;
         sub_q <= SUB_ZERO;
         wdata_q <= STAMP_RST;
         vld_q <= 1'b0;
         abt_q <= 1'b0;
         data_q <= STAMP_RST;
         date_ok_q <= 1'b0;
         time_ok_q <= 1'b0;
         sync_q <= 1'b0;
         nmt_vld_q <= 1'b0;
         nmt_cmd_q <= CSO_CMD_PREOP;
         rdy_q <= 1'b1;
      end else begin
         st_q <= st_d;
         req_q <= req_d;
         wr_q <= wr_d;
         idx_q <= idx_d;
         sub_q <= sub_d;
         wdata_q <= wdata_d;
         vld_q <= vld_d;
         abt_q <= abt_d;
         data_q <= data_d;
         date_ok_q <= date_ok_d;
         time_ok_q <= time_ok_d;
         sync_q <= sync_req_i;
         nmt_vld_q <= nmt_req_i;
         nmt_cmd_q <= nmt_cmd_i;
         rdy_q <= rdy_d;
      end
   end

   assign lnk.req = req_q;
   assign lnk.wr = wr_q;
   assign lnk.idx = idx_q;
   assign lnk.sub = sub_q;
   assign lnk.wdata = wdata_q;
   assign lnk.sync = sync_q;
   assign lnk.nmt_vld = nmt_vld_q;
   assign lnk.nmt_cmd = nmt_cmd_q;
   assign cmd_rdy_o = rdy_q;
   assign rsp_vld_o = vld_q;
   assign rsp_abort_o = abt_q;
   assign rsp_data_o = data_q;
endmodule : cso_mst

// >>> testbench/cso_checker.sv
// Concurrent checks on the link that joins the master end to the device end.
module cso_checker
   import cso_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic req,
   input wire logic wr,
   input wire logic [15:0] idx,
   input wire logic [7:0] sub,
   input wire logic [31:0] wdata,
   input wire logic ack,
   input wire logic abort,
   input wire logic [31:0] rdata,
   input wire logic sync,
   input wire logic nmt_vld,
   input wire cso_nmt_cmd_t nmt_cmd,
   input wire cso_nmt_t nmt_state
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!nrst_i);

   a_answer_next: assert property (req |=> ack ^ abort)
      else $error("request not answered in the next cycle");
   a_no_stray_answer: assert property (ack || abort |-> $past(req))
      else $error("answer without a request");
   a_req_gap: assert property (req |=> !req [*2])
      else $error("requests closer than three cycles");
   a_wrap_taken: assert property (req && wr && idx == IDX_SYNC_WRAP && sub == SUB_ZERO &&
      wdata >= 32'(WRAP_MIN) && wdata <= 32'(WRAP_MAX) |=> ack)
      else $error("legal wrap value write not acknowledged");
   a_policy_refused: assert property (req && wr && idx == IDX_ERR_BEH && wdata > 32'(POL_STOP) |=> abort)
      else $error("policy write above stop code not refused");
   a_sub_zero_refused: assert property (req && wr && sub == SUB_ZERO && idx != IDX_SYNC_WRAP |=> abort)
      else $error("write to entry count not refused");
   a_store_read_refused: assert property (req && !wr && idx == IDX_STORE |=> abort)
      else $error("read of store trigger not refused");
   a_rdata_holds: assert property (!ack && !abort |-> $stable(rdata))
      else $error("read data changed without an answer");
   a_stop_cmd: assert property (nmt_vld && nmt_cmd == CSO_CMD_STOP |-> ##[1:2] nmt_state == CSO_STOPPED)
      else $error("stop command did not stop the device");
   a_stopped_holds: assert property (nmt_state == CSO_STOPPED && !nmt_vld && !$past(nmt_vld)
      |=> nmt_state == CSO_STOPPED)
      else $error("left stopped without a command");
   a_no_err_oper: assert property (nmt_state != CSO_OPER && !nmt_vld && !$past(nmt_vld)
      |=> nmt_state != CSO_OPER)
      else $error("entered operational without a command");

   c_wrap_write: cover property (req && wr && idx == IDX_SYNC_WRAP ##1 ack);
   c_refused: cover property (abort);
   c_stopped: cover property ($rose(nmt_state == CSO_STOPPED));
   c_sync: cover property (sync);
endmodule : cso_checker

// >>> testbench/canopen_sync_verify_error_policy_test.sv
// Self-checking bench for the master end and the device end joined by the link.
module canopen_sync_verify_error_policy_test import cso_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic nv_clr = 1'b0;
   logic comm_err = 1'b0;
   logic int_err = 1'b0;
   logic cmd_vld = 1'b0;
   logic cmd_wr = 1'b0;
   logic [15:0] cmd_idx = 16'h0000;
   logic [7:0] cmd_sub = 8'h00;
   logic [31:0] cmd_wdata = 32'h00000000;
   logic sync_req = 1'b0;
   logic nmt_req = 1'b0;
   cso_nmt_cmd_t nmt_cmd = CSO_CMD_START;
   logic cmd_rdy, rsp_vld, rsp_abort, ok;
   logic [31:0] rsp_data, day, ms;
   logic [7:0] sync_cnt, wrap, wv, c;
   cso_nmt_t nmt_state, st, want;
   logic [33:0] exp_q[$];
   logic [33:0] e;
   logic [7:0] wtab[7] = '{8'h00, 8'h01, 8'h02, 8'hF0, 8'hF1, 8'hFF, 8'h00};
   int err_total = 0;
   int checks = 0;

   cso_link_if lnk();
   cso_mst cso_mst_i (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .cmd_vld_i(cmd_vld), .cmd_wr_i(cmd_wr),
      .cmd_idx_i(cmd_idx), .cmd_sub_i(cmd_sub), .cmd_wdata_i(cmd_wdata), .sync_req_i(sync_req),
      .nmt_req_i(nmt_req), .nmt_cmd_i(nmt_cmd), .lnk(lnk.mst), .cmd_rdy_o(cmd_rdy), .rsp_vld_o(rsp_vld),
      .rsp_abort_o(rsp_abort), .rsp_data_o(rsp_data));
   cso_dev cso_dev_i (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .nv_clr_i(nv_clr), .comm_err_i(comm_err),
      .int_err_i(int_err), .lnk(lnk.dev), .nmt_state_o(nmt_state), .sync_cnt_o(sync_cnt), .wrap_o(wrap));
   cso_checker cso_checker_i (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .req(lnk.req), .wr(lnk.wr),
      .idx(lnk.idx), .sub(lnk.sub), .wdata(lnk.wdata), .ack(lnk.ack), .abort(lnk.abort), .rdata(lnk.rdata),
      .sync(lnk.sync), .nmt_vld(lnk.nmt_vld), .nmt_cmd(lnk.nmt_cmd), .nmt_state(lnk.nmt_state));

   initial begin
      forever #10 ref_clk_i = ~ref_clk_i;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic end_sim();
      if (err_total == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_sim

   task automatic rst();
      @(posedge ref_clk_i) nrst_i <= 1'b0;
      @(posedge ref_clk_i);
      @(posedge ref_clk_i) nrst_i <= 1'b1;
   endtask : rst

   // One command at a time: the note of the expected answer goes in before the command is offered.
   task automatic cmd(input logic w, input logic [15:0] ix, input logic [7:0] sb, input logic [31:0] d,
                      input logic [33:0] ex);
      int n = 0;
      @(negedge ref_clk_i);
      while (cmd_rdy !== 1'b1 && n < 20) begin
         @(negedge ref_clk_i);
         n++;
      end
      exp_q.push_back(ex);
      @(posedge ref_clk_i);
      cmd_vld <= 1'b1;
      cmd_wr <= w;
      cmd_idx <= ix;
      cmd_sub <= sb;
      cmd_wdata <= d;
      @(posedge ref_clk_i) cmd_vld <= 1'b0;
      n = 0;
      while (exp_q.size() != 0 && n < 20) begin
         @(negedge ref_clk_i);
         n++;
      end
   endtask : cmd

   task automatic rd(input logic [15:0] ix, input logic [7:0] sb, input logic [31:0] ed);
      cmd(1'b0, ix, sb, 32'h00000000, {2'b10, ed});
   endtask : rd

   task automatic wr(input logic [15:0] ix, input logic [7:0] sb, input logic [31:0] d, input logic ea);
      cmd(1'b1, ix, sb, d, {1'b0, ea, 32'h00000000});
   endtask : wr

   task automatic pulse_sync(input logic [7:0] ex);
      @(posedge ref_clk_i) sync_req <= 1'b1;
      @(posedge ref_clk_i) sync_req <= 1'b0;
      @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      chk(sync_cnt, ex);
   endtask : pulse_sync

   task automatic nmt(input cso_nmt_cmd_t nc);
      @(posedge ref_clk_i);
      nmt_req <= 1'b1;
      nmt_cmd <= nc;
      @(posedge ref_clk_i) nmt_req <= 1'b0;
      @(posedge ref_clk_i);
      @(negedge ref_clk_i);
   endtask : nmt

   task automatic pulse_err(input logic internal, input cso_nmt_t ex);
      @(posedge ref_clk_i);
      comm_err <= !internal;
      int_err <= internal;
      @(posedge ref_clk_i);
      comm_err <= 1'b0;
      int_err <= 1'b0;
      @(negedge ref_clk_i);
      chk(nmt_state, ex);
   endtask : pulse_err

   always @(posedge ref_clk_i) begin
      if (rsp_vld === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk(32'h00000001, 32'h00000000);
         end else begin
            e = exp_q.pop_front();
            chk(rsp_abort, e[32]);
            if (e[33]) begin
               chk(rsp_data, e[31:0]);
            end
         end
      end
   end

   initial begin
      repeat (8000) @(posedge ref_clk_i);
      err_total++;
      end_sim();
   end

   initial begin
      void'($urandom(32'hB352F638));
      rst();
      @(posedge ref_clk_i) nv_clr <= 1'b1;
      @(posedge ref_clk_i) nv_clr <= 1'b0;
      rst();
      rd(IDX_SYNC_WRAP, SUB_ZERO, {24'h000000, WRAP_RST});
      rd(IDX_ERR_BEH, SUB_ZERO, {24'h000000, ARRAY_ENTRIES});
      rd(IDX_VERIFY, SUB_ZERO, {24'h000000, ARRAY_ENTRIES});
      rd(IDX_ERR_BEH, SUB_FIRST, {24'h000000, COMM_POL_RST});
      rd(IDX_ERR_BEH, SUB_SECOND, {24'h000000, INT_POL_RST});
      rd(IDX_VERIFY, SUB_FIRST, STAMP_RST);
      pulse_sync(CNT_RST);
      cmd(1'b0, IDX_STORE, SUB_FIRST, 32'h00000000, {2'b01, 32'h00000000});
      wr(IDX_VERIFY, SUB_ZERO, 32'h00000000, 1'b1);
      wr(16'h1234, SUB_ZERO, 32'h00000000, 1'b1);
      wtab[6] = 8'($urandom_range(32'h000000F0, 32'h00000002));
      wv = WRAP_RST;
      foreach (wtab[k]) begin
         ok = wtab[k] >= WRAP_MIN && wtab[k] <= WRAP_MAX;
         wr(IDX_SYNC_WRAP, SUB_ZERO, {24'h000000, wtab[k]}, !ok);
         if (ok) begin
            wv = wtab[k];
         end
         chk(wrap, wv);
         rd(IDX_SYNC_WRAP, SUB_ZERO, {24'h000000, wv});
      end
      // Counting runs 1, 2, 3 and wraps; lowering the wrap value to the running count of two forces a reload.
      wv = 8'h03;
      wr(IDX_SYNC_WRAP, SUB_ZERO, {24'h000000, wv}, 1'b0);
      for (int k = 0; k < 7; k++) begin
         if (k == 5) begin
            wv = 8'h02;
            wr(IDX_SYNC_WRAP, SUB_ZERO, {24'h000000, wv}, 1'b0);
         end
         c = (k < 5) ? 8'(k % 3 + 1) : 8'(k - 4);
         pulse_sync(c);
      end
      day = $urandom_range(32'h0000FFFF);
      ms = $urandom_range(32'h05265BFF);
      wr(IDX_VERIFY, SUB_FIRST, day, 1'b0);
      wr(IDX_STORE, SUB_FIRST, 32'h00000001, 1'b1);
      wr(IDX_VERIFY, SUB_SECOND, ms, 1'b0);
      wr(IDX_STORE, SUB_FIRST, 32'h00000001, 1'b0);
      wr(IDX_VERIFY, SUB_FIRST, 32'h00000000, 1'b0);
      rst();
      rd(IDX_VERIFY, SUB_FIRST, day);
      rd(IDX_VERIFY, SUB_SECOND, ms);
      rd(IDX_SYNC_WRAP, SUB_ZERO, {24'h000000, WRAP_RST});
      for (int ek = 0; ek < 2; ek++) begin
         for (int pk = 0; pk < 3; pk++) begin
            wr(IDX_ERR_BEH, ek ? SUB_SECOND : SUB_FIRST, 32'(pk), 1'b0);
            for (int sk = 0; sk < 2; sk++) begin
               nmt(sk ? CSO_CMD_PREOP : CSO_CMD_START);
               st = sk ? CSO_PREOP : CSO_OPER;
               chk(nmt_state, st);
               want = pk == 2 ? CSO_STOPPED : (pk == 0 && sk == 0) ? CSO_PREOP : st;
               pulse_err(ek == 1, want);
            end
         end
      end
      wr(IDX_ERR_BEH, SUB_FIRST, 32'h00000003, 1'b1);
      rd(IDX_ERR_BEH, SUB_FIRST, 32'h00000002);
      rd(IDX_ERR_BEH, SUB_SECOND, 32'h00000002);
      nmt(CSO_CMD_STOP);
      chk(nmt_state, CSO_STOPPED);
      chk(exp_q.size(), 32'h00000000);
      end_sim();
   end
endmodule : canopen_sync_verify_error_policy_test
